// File: rtl/dsof_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dsof_defs.svh"

// What this block does
// - Homing-complete flag sets when homing finishes or a preset is executed.
// - Coordinates-valid flag follows the established coordinate system.
// - Flag shows electrical home coordinates are enabled.
// - Flag shows another preset is needed before the motor may run.
// - Wrap flag inverts each time the position leaves the wrap range.
// - Forward and reverse software limit flags follow the reached limits.
// - One pulse per full revolution advanced from the preset position.
// - Wrap origin flag only while wrap is enabled and motor at origin.
// - Flag while position is inside the active operation data area.
// - Eight flags, each while position lies inside its own zone window.
// - Flag only when both safe-off inputs are off together.
// - Flag when at least one safe-off input is off.
// - Two user flags, each AND or OR of two selected flags.
// - Flags stay on while torque or speed clamping is active.
// - Flag stays on while the profile generator runs.
// - Flag stays on for the whole stored-data sequence.
// - Flag on while the drive waits in a dwell or delay interval.
// - Latched flags for the low and high event jump triggers.
// - Latched flag when the sequence steps on through the next-step input.
// - Flags for direct command acceptable and direct buffer being written.
// - Flag once torque reaches the overload detection threshold.
// - Flags for main power on, brake releasing and regeneration.
// - Constant-off code always drives the terminal inactive.
module dsof_top
	import dsof_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_home_start,
	input wire logic i_home_finish,
	input wire logic i_preset_exec,
	input wire logic i_coords_set,
	input wire logic i_electrical_origin_enabled,
	input wire logic i_represet_required,
	input wire logic i_wrap_exceed,
	input wire logic i_wrap_enable,
	input wire logic i_at_wrap_origin,
	input wire logic i_fwd_soft_limit,
	input wire logic i_rev_soft_limit,
	input wire logic signed [31:0] i_fb_position,
	input wire logic signed [31:0] i_op_area_lo,
	input wire logic signed [31:0] i_op_area_hi,
	input wire logic [7:0][31:0] i_zone_lo,
	input wire logic [7:0][31:0] i_zone_hi,
	input wire logic i_main_power,
	input wire logic i_brake_release,
	input wire logic i_regen,
	input wire logic i_safe_off_input_1,
	input wire logic i_safe_off_input_2,
	input wire logic [7:0] i_user0_sel_a,
	input wire logic [7:0] i_user0_sel_b,
	input wire logic i_user0_op,
	input wire logic [7:0] i_user1_sel_a,
	input wire logic [7:0] i_user1_sel_b,
	input wire logic i_user1_op,
	input wire logic i_torque_clamp,
	input wire logic i_speed_clamp,
	input wire logic i_profile_gen,
	input wire logic i_stored_seq,
	input wire logic i_dwell_wait,
	input wire logic i_low_event_jump,
	input wire logic i_high_event_jump,
	input wire logic i_step_advance,
	input wire logic i_latch_clear,
	input wire logic i_direct_cmd_accept,
	input wire logic i_direct_cmd_writing,
	input wire logic [15:0] i_torque,
	input wire logic [15:0] i_overload_threshold,
	input wire logic [7:0] i_term_sel_0,
	input wire logic [7:0] i_term_sel_1,
	input wire logic [7:0] i_term_sel_2,
	input wire logic [7:0] i_term_sel_3,
	output logic o_term_0,
	output logic o_term_1,
	output logic o_term_2,
	output logic o_term_3
);

	// Picks one flag by assignment code; codes below the flag range read inactive
	function automatic logic flag_of(input dsof_flags_t flags, input dsof_code_t code);
		logic result;
		result = 1'h0;
		if (code[7])
		begin
			result = flags[code[6:0]];
		end
		return result;
	endfunction

	function automatic logic user_combine(input dsof_flags_t flags, input dsof_code_t sel_a,
		input dsof_code_t sel_b, input logic op);
		logic a;
		logic b;
		logic result;
		a = flag_of(flags, sel_a);
		b = flag_of(flags, sel_b);
		result = (dsof_user_op_e'(op) == DSOF_OP_OR) ? (a | b) : (a & b);
		return result;
	endfunction

	logic homing_done;
	logic wrap_overflow_toggle;
	logic per_revolution_pulse;
	logic signed [31:0] rev_base;
	logic signed [31:0] rev_diff;
	logic low_event_jump_latch;
	logic high_event_jump_latch;
	logic step_advance_latch;
	logic [1:0] safe_in;
	logic [`DSOF_ZONES-1:0] zone_hit;
	logic op_data_area_flag;
	dsof_flags_t base_flags;
	dsof_flags_t flags;
	logic [3:0] next_term;
	dsof_code_t term_sel [4];

	dsof_sync #(
		.WIDTH(2)
	) u_safe_sync (
		.i_clock(i_clock),
		.i_nrst(i_nrst),
		.i_async({i_safe_off_input_2, i_safe_off_input_1}),
		.o_level(safe_in)
	);

	// Set wins over a new homing start in the same cycle
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			homing_done <= `DSOF_RESET_LEVEL;
		end
		else if (i_home_finish || i_preset_exec)
		begin
			homing_done <= 1'h1;
		end
		else if (i_home_start)
		begin
			homing_done <= 1'h0;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wrap_overflow_toggle <= `DSOF_RESET_LEVEL;
		end
		else if (i_wrap_exceed)
		begin
			wrap_overflow_toggle <= !wrap_overflow_toggle;
		end
	end

	assign rev_diff = i_fb_position - rev_base;

	// Reference follows backward travel without a pulse, so a revolution travelled again after reversing pulses again
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rev_base <= 32'sh0000_0000;
			per_revolution_pulse <= `DSOF_RESET_LEVEL;
		end
		else if (i_preset_exec)
		begin
			rev_base <= i_fb_position;
			per_revolution_pulse <= 1'h0;
		end
		else if (rev_diff >= $signed(`DSOF_REV_STEPS))
		begin
			rev_base <= rev_base + $signed(`DSOF_REV_STEPS);
			per_revolution_pulse <= 1'h1;
		end
		else if (rev_diff <= -$signed(`DSOF_REV_STEPS))
		begin
			rev_base <= rev_base - $signed(`DSOF_REV_STEPS);
			per_revolution_pulse <= 1'h0;
		end
		else
		begin
			per_revolution_pulse <= 1'h0;
		end
	end

	// Event latches; a trigger in the clearing cycle keeps the latch set
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			low_event_jump_latch <= `DSOF_RESET_LEVEL;
			high_event_jump_latch <= `DSOF_RESET_LEVEL;
			step_advance_latch <= `DSOF_RESET_LEVEL;
		end
		else
		begin
			low_event_jump_latch <= i_low_event_jump || (low_event_jump_latch && !i_latch_clear);
			high_event_jump_latch <= i_high_event_jump || (high_event_jump_latch && !i_latch_clear);
			step_advance_latch <= i_step_advance || (step_advance_latch && !i_latch_clear);
		end
	end

	// A window with low above high wraps through the ends of the range
	assign op_data_area_flag = (i_op_area_lo <= i_op_area_hi)
		? (i_fb_position >= i_op_area_lo && i_fb_position <= i_op_area_hi)
		: (i_fb_position >= i_op_area_lo || i_fb_position <= i_op_area_hi);

	genvar z;
	generate
		for (z = 0; z < `DSOF_ZONES; z++)
		begin : g_zone
			logic signed [31:0] lo;
			logic signed [31:0] hi;
			assign lo = $signed(i_zone_lo[z]);
			assign hi = $signed(i_zone_hi[z]);
			assign zone_hit[z] = (lo <= hi)
				? (i_fb_position >= lo && i_fb_position <= hi)
				: (i_fb_position >= lo || i_fb_position <= hi);
		end
	endgenerate

	always_comb
	begin
		base_flags = '0;
		base_flags[7'(`DSOF_CODE_CONST_OFF)] = 1'h0;
		base_flags[7'(`DSOF_CODE_HOME_DONE)] = homing_done;
		base_flags[7'(`DSOF_CODE_COORDS_VALID)] = i_coords_set;
		base_flags[7'(`DSOF_CODE_ELEC_ORIGIN)] = i_electrical_origin_enabled;
		base_flags[7'(`DSOF_CODE_REPRESET)] = i_represet_required;
		base_flags[7'(`DSOF_CODE_WRAP_TOGGLE)] = wrap_overflow_toggle;
		base_flags[7'(`DSOF_CODE_FWD_LIMIT)] = i_fwd_soft_limit;
		base_flags[7'(`DSOF_CODE_REV_LIMIT)] = i_rev_soft_limit;
		base_flags[7'(`DSOF_CODE_REV_PULSE)] = per_revolution_pulse;
		base_flags[7'(`DSOF_CODE_WRAP_ORIGIN)] = i_wrap_enable && i_at_wrap_origin;
		base_flags[7'(`DSOF_CODE_OP_AREA)] = op_data_area_flag;
		for (int k = 0; k < `DSOF_ZONES; k++)
		begin
			base_flags[7'(`DSOF_CODE_ZONE_BASE) + 7'(k)] = zone_hit[k];
		end
		base_flags[7'(`DSOF_CODE_MAIN_POWER)] = i_main_power;
		base_flags[7'(`DSOF_CODE_BRAKE_FREE)] = i_brake_release;
		base_flags[7'(`DSOF_CODE_REGEN)] = i_regen;
		base_flags[7'(`DSOF_CODE_BOTH_SAFE_OFF)] = !safe_in[0] && !safe_in[1];
		base_flags[7'(`DSOF_CODE_ANY_SAFE_OFF)] = !safe_in[0] || !safe_in[1];
		base_flags[7'(`DSOF_CODE_TORQUE_CLAMP)] = i_torque_clamp;
		base_flags[7'(`DSOF_CODE_SPEED_CLAMP)] = i_speed_clamp;
		base_flags[7'(`DSOF_CODE_PROFILE_GEN)] = i_profile_gen;
		base_flags[7'(`DSOF_CODE_STORED_SEQ)] = i_stored_seq;
		base_flags[7'(`DSOF_CODE_DWELL_WAIT)] = i_dwell_wait;
		base_flags[7'(`DSOF_CODE_LOW_JUMP)] = low_event_jump_latch;
		base_flags[7'(`DSOF_CODE_HIGH_JUMP)] = high_event_jump_latch;
		base_flags[7'(`DSOF_CODE_STEP_ADV)] = step_advance_latch;
		base_flags[7'(`DSOF_CODE_DCMD_ACCEPT)] = i_direct_cmd_accept;
		base_flags[7'(`DSOF_CODE_DCMD_WRITING)] = i_direct_cmd_writing;
		base_flags[7'(`DSOF_CODE_OVERLOAD)] = i_torque >= i_overload_threshold;
	end

	// User flags draw only on base flags, so they cannot feed each other in a loop
	always_comb
	begin
		flags = base_flags;
		flags[7'(`DSOF_CODE_USER_0)] = user_combine(base_flags, i_user0_sel_a, i_user0_sel_b, i_user0_op);
		flags[7'(`DSOF_CODE_USER_1)] = user_combine(base_flags, i_user1_sel_a, i_user1_sel_b, i_user1_op);
	end

	assign term_sel[0] = i_term_sel_0;
	assign term_sel[1] = i_term_sel_1;
	assign term_sel[2] = i_term_sel_2;
	assign term_sel[3] = i_term_sel_3;

	genvar t;
	generate
		for (t = 0; t < 4; t++)
		begin : g_term
			assign next_term[t] = flag_of(flags, term_sel[t]);
		end
	endgenerate

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_term_0 <= `DSOF_RESET_LEVEL;
			o_term_1 <= `DSOF_RESET_LEVEL;
			o_term_2 <= `DSOF_RESET_LEVEL;
			o_term_3 <= `DSOF_RESET_LEVEL;
		end
		else
		begin
			o_term_0 <= next_term[0];
			o_term_1 <= next_term[1];
			o_term_2 <= next_term[2];
			o_term_3 <= next_term[3];
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);

	sequence s_preset_seen;
		i_preset_exec || i_home_finish;
	endsequence

	sequence s_flag_on_next;
		##1 homing_done;
	endsequence

	property p_homing_done;
		s_preset_seen |-> s_flag_on_next;
	endproperty
	a_homing_done: assert property (p_homing_done)
		else $error("homing flag did not set after preset or homing end");

	property p_wrap_toggle;
		i_wrap_exceed |=> (wrap_overflow_toggle != $past(wrap_overflow_toggle));
	endproperty
	a_wrap_toggle: assert property (p_wrap_toggle)
		else $error("wrap flag did not invert on overflow");

	property p_wrap_hold;
		!i_wrap_exceed |=> $stable(wrap_overflow_toggle);
	endproperty
	a_wrap_hold: assert property (p_wrap_hold)
		else $error("wrap flag changed without overflow");

	property p_rev_pulse_cause;
		per_revolution_pulse |-> $past(rev_diff) >= $signed(`DSOF_REV_STEPS);
	endproperty
	a_rev_pulse_cause: assert property (p_rev_pulse_cause)
		else $error("revolution pulse without a full revolution");

	property p_const_off;
		(i_term_sel_0 == `DSOF_CODE_CONST_OFF) |=> !o_term_0;
	endproperty
	a_const_off: assert property (p_const_off)
		else $error("constant-off code drove the terminal active");

	property p_unassigned_code;
		!i_term_sel_1[7] |=> !o_term_1;
	endproperty
	a_unassigned_code: assert property (p_unassigned_code)
		else $error("unassigned code drove the terminal active");

	sequence s_jump_trigger;
		i_low_event_jump ##1 1'h1;
	endsequence

	property p_low_jump_latch;
		s_jump_trigger |-> low_event_jump_latch;
	endproperty
	a_low_jump_latch: assert property (p_low_jump_latch)
		else $error("low jump trigger not latched");

	property p_step_latch_cause;
		$rose(step_advance_latch) |-> $past(i_step_advance);
	endproperty
	a_step_latch_cause: assert property (p_step_latch_cause)
		else $error("step latch set without the next-step input");

	property p_safe_off_pair;
		flags[7'(`DSOF_CODE_BOTH_SAFE_OFF)] |-> flags[7'(`DSOF_CODE_ANY_SAFE_OFF)] && !safe_in[0];
	endproperty
	a_safe_off_pair: assert property (p_safe_off_pair)
		else $error("both-off monitor active while an input is on");

	property p_wrap_origin_gate;
		!i_wrap_enable |-> !flags[7'(`DSOF_CODE_WRAP_ORIGIN)];
	endproperty
	a_wrap_origin_gate: assert property (p_wrap_origin_gate)
		else $error("wrap origin flag active with wrap disabled");

	property p_fwd_limit_term;
		(i_term_sel_2 == `DSOF_CODE_FWD_LIMIT) |=> (o_term_2 == $past(i_fwd_soft_limit));
	endproperty
	a_fwd_limit_term: assert property (p_fwd_limit_term)
		else $error("forward limit terminal does not follow the limit");

	property p_overload_term;
		(i_term_sel_3 == `DSOF_CODE_OVERLOAD) |=> (o_term_3 == ($past(i_torque) >= $past(i_overload_threshold)));
	endproperty
	a_overload_term: assert property (p_overload_term)
		else $error("overload terminal does not match the torque threshold");

endmodule

`default_nettype wire

// File: common/dsof_defs.svh
`ifndef DSOF_DEFS_SVH
`define DSOF_DEFS_SVH

// Assignment codes of the selectable status flags
`define DSOF_CODE_CONST_OFF 8'h80
`define DSOF_CODE_HOME_DONE 8'h90
`define DSOF_CODE_COORDS_VALID 8'h91
`define DSOF_CODE_ELEC_ORIGIN 8'h92
`define DSOF_CODE_REPRESET 8'h95
`define DSOF_CODE_WRAP_TOGGLE 8'h98
`define DSOF_CODE_FWD_LIMIT 8'h99
`define DSOF_CODE_REV_LIMIT 8'h9a
`define DSOF_CODE_REV_PULSE 8'h9b
`define DSOF_CODE_WRAP_ORIGIN 8'h9c
`define DSOF_CODE_OP_AREA 8'h9f
`define DSOF_CODE_ZONE_BASE 8'ha0
`define DSOF_CODE_MAIN_POWER 8'ha8
`define DSOF_CODE_BRAKE_FREE 8'ha9
`define DSOF_CODE_REGEN 8'haa
`define DSOF_CODE_BOTH_SAFE_OFF 8'hac
`define DSOF_CODE_ANY_SAFE_OFF 8'had
`define DSOF_CODE_USER_0 8'hb4
`define DSOF_CODE_USER_1 8'hb5
`define DSOF_CODE_TORQUE_CLAMP 8'hc0
`define DSOF_CODE_SPEED_CLAMP 8'hc1
`define DSOF_CODE_PROFILE_GEN 8'hc4
`define DSOF_CODE_STORED_SEQ 8'hc6
`define DSOF_CODE_DWELL_WAIT 8'hc7
`define DSOF_CODE_LOW_JUMP 8'hc8
`define DSOF_CODE_HIGH_JUMP 8'hc9
`define DSOF_CODE_STEP_ADV 8'hca
`define DSOF_CODE_DCMD_ACCEPT 8'hcc
`define DSOF_CODE_DCMD_WRITING 8'hcd
`define DSOF_CODE_OVERLOAD 8'hce

// Feedback counts per motor revolution
`define DSOF_REV_STEPS 32'h0000_2710
// Number of zone windows
`define DSOF_ZONES 8
// Reset value of the registered flags and the terminals
`define DSOF_RESET_LEVEL 1'h0

`endif

// File: common/dsof_pkg.sv
package dsof_pkg;

	typedef logic [7:0] dsof_code_t;
	typedef logic [127:0] dsof_flags_t;

	typedef enum logic
	{
		DSOF_OP_AND = 1'h0,
		DSOF_OP_OR = 1'h1
	} dsof_user_op_e;

endpackage

// File: rtl/dsof_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Three-stage synchroniser; the output follows once stages two and three agree
module dsof_sync #(
	parameter int WIDTH = 2
)
(
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_level
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			always_ff @(posedge i_clock or negedge i_nrst)
			begin
				if (!i_nrst)
				begin
					stage1[g] <= 1'h0;
					stage2[g] <= 1'h0;
					stage3[g] <= 1'h0;
					o_level[g] <= 1'h0;
				end
				else
				begin
					stage1[g] <= i_async[g];
					stage2[g] <= stage1[g];
					stage3[g] <= stage2[g];
					if (stage2[g] == stage3[g])
					begin
						o_level[g] <= stage3[g];
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// File: sim/dsof_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Host side that samples the four terminals and counts rising edges on terminal 2
module dsof_host_model
	import dsof_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [3:0] i_term,
	output logic [15:0] o_rises
);
	logic [3:0] seen;

	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			seen <= '0;
			o_rises <= '0;
		end
		else
		begin
			seen <= i_term;
			if (i_term[2] && !seen[2])
			begin
				o_rises <= o_rises + 16'h0001;
			end
		end
	end
endmodule

`default_nettype wire

// File: sim/dsof_top_test.sv
`timescale 1ns/100ps
`default_nettype none

module dsof_top_test
	import dsof_pkg::*;
;
	logic clk = 1'h0, nrst = 1'h0, wen = 1'h0, worg = 1'h0, so1 = 1'h1, so2 = 1'h1, u0op = 1'h0, u1op = 1'h1;
	logic [14:0] lv = '0;
	logic [7:0] pu = '0;
	wire [3:0] t;
	logic [15:0] trq = '0, thr = 16'h03e8, rises;
	logic signed [31:0] pos = '0, alo = 32'shffff_fff6, ahi = 32'sh0000_000a;
	logic [7:0][31:0] zlo = '0, zhi = '0;
	dsof_code_t sel [4] = '{default: 8'h80};
	dsof_code_t u0a = 8'h91, u0b = 8'h92;
	int failures = 0, samples_checked = 0, cyc = 0;
	localparam dsof_code_t LC [15] = '{8'h91, 8'h92, 8'h95, 8'h99, 8'h9a, 8'ha8, 8'ha9, 8'haa, 8'hc0, 8'hc1,
		8'hc4, 8'hc6, 8'hc7, 8'hcc, 8'hcd};

	dsof_top i_dut (.i_clock(clk), .i_nrst(nrst), .i_home_start(pu[0]), .i_home_finish(pu[1]),
		.i_preset_exec(pu[2]), .i_coords_set(lv[0]), .i_electrical_origin_enabled(lv[1]),
		.i_represet_required(lv[2]), .i_wrap_exceed(pu[3]), .i_wrap_enable(wen), .i_at_wrap_origin(worg),
		.i_fwd_soft_limit(lv[3]), .i_rev_soft_limit(lv[4]), .i_fb_position(pos), .i_op_area_lo(alo),
		.i_op_area_hi(ahi), .i_zone_lo(zlo), .i_zone_hi(zhi), .i_main_power(lv[5]), .i_brake_release(lv[6]),
		.i_regen(lv[7]), .i_safe_off_input_1(so1), .i_safe_off_input_2(so2), .i_user0_sel_a(u0a),
		.i_user0_sel_b(u0b), .i_user0_op(u0op), .i_user1_sel_a(u0a), .i_user1_sel_b(u0b), .i_user1_op(u1op),
		.i_torque_clamp(lv[8]), .i_speed_clamp(lv[9]), .i_profile_gen(lv[10]), .i_stored_seq(lv[11]),
		.i_dwell_wait(lv[12]), .i_low_event_jump(pu[4]), .i_high_event_jump(pu[5]), .i_step_advance(pu[6]),
		.i_latch_clear(pu[7]), .i_direct_cmd_accept(lv[13]), .i_direct_cmd_writing(lv[14]), .i_torque(trq),
		.i_overload_threshold(thr), .i_term_sel_0(sel[0]), .i_term_sel_1(sel[1]), .i_term_sel_2(sel[2]),
		.i_term_sel_3(sel[3]), .o_term_0(t[0]), .o_term_1(t[1]), .o_term_2(t[2]), .o_term_3(t[3]));

	dsof_host_model i_host (.i_clock(clk), .i_nrst(nrst), .i_term(t), .o_rises(rises));

	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failures++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic ck(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s expected %b seen %b", nm, e, g);
		end
	endtask

	// One-cycle pulse on the chosen event inputs
	task automatic pm(input logic [7:0] m);
		@(posedge clk);
		pu <= m;
		@(posedge clk);
		pu <= '0;
		w(2);
	endtask

	task automatic t_levels();
		for (int i = 0; i < 15; i++)
		begin
			@(posedge clk);
			sel[0] <= LC[i];
			sel[1] <= LC[(i + 1) % 15];
			sel[2] <= LC[i];
			lv <= 15'h0001 << i;
			w(2);
			ck("level flag on", 1'h1, t[0]);
			ck("level flag mirror", 1'h1, t[2]);
			ck("neighbour off", 1'h0, t[1]);
			@(posedge clk);
			lv <= ~(15'h0001 << i);
			w(2);
			ck("level flag off", 1'h0, t[0]);
			ck("neighbour on", 1'h1, t[1]);
		end
		@(posedge clk);
		lv <= '0;
		$display("test levels done");
	endtask

	task automatic t_home();
		@(posedge clk);
		sel[0] <= 8'h90;
		pm(8'h01);
		ck("home cleared", 1'h0, t[0]);
		pm(8'h02);
		ck("home finished", 1'h1, t[0]);
		pm(8'h01);
		ck("home restarted", 1'h0, t[0]);
		pm(8'h04);
		ck("home by preset", 1'h1, t[0]);
		pm(8'h03);
		ck("home set wins", 1'h1, t[0]);
		$display("test home done");
	endtask

	task automatic t_wrap();
		@(posedge clk);
		sel[0] <= 8'h98;
		sel[1] <= 8'h9c;
		wen <= 1'h1;
		worg <= 1'h1;
		w(2);
		ck("wrap origin", 1'h1, t[1]);
		ck("toggle idle", 1'h0, t[0]);
		pm(8'h08);
		ck("toggle first", 1'h1, t[0]);
		@(posedge clk);
		wen <= 1'h0;
		w(2);
		ck("origin wrap off", 1'h0, t[1]);
		ck("toggle holds", 1'h1, t[0]);
		pm(8'h08);
		ck("toggle second", 1'h0, t[0]);
		@(posedge clk);
		wen <= 1'h1;
		worg <= 1'h0;
		w(2);
		ck("origin away", 1'h0, t[1]);
		$display("test wrap done");
	endtask

	task automatic t_rev();
		logic [15:0] r0;
		@(posedge clk);
		sel[2] <= 8'h9b;
		pos <= 32'sh0000_1388;
		pm(8'h04);
		r0 = rises;
		@(posedge clk);
		pos <= 32'sh0000_3a97;
		w(4);
		ck("no pulse short", 1'h1, rises === r0);
		@(posedge clk);
		pos <= 32'sh0000_3a98;
		w(4);
		ck("pulse one rev", 1'h1, rises === r0 + 16'h0001);
		ck("pulse ended", 1'h0, t[2]);
		@(posedge clk);
		pos <= 32'sh0000_61a8;
		w(4);
		@(posedge clk);
		pos <= 32'sh0000_1388;
		w(4);
		ck("backward quiet", 1'h1, rises === r0 + 16'h0002);
		@(posedge clk);
		pos <= 32'sh0000_3a98;
		w(4);
		ck("pulse after back", 1'h1, rises === r0 + 16'h0003);
		$display("test revolution done");
	endtask

	task automatic t_area();
		@(posedge clk);
		for (int k = 0; k < 8; k++)
		begin
			zlo[k] <= 32'(k * 100);
			zhi[k] <= 32'(k * 100 + 50);
		end
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk);
			sel[0] <= 8'ha0 + 8'(k);
			sel[1] <= 8'ha0 + 8'((k + 1) % 8);
			pos <= 32'(k * 100 + 50);
			w(2);
			ck("zone edge in", 1'h1, t[0]);
			ck("other zone", 1'h0, t[1]);
			@(posedge clk);
			pos <= 32'(k * 100 + 51);
			w(2);
			ck("zone past edge", 1'h0, t[0]);
		end
		@(posedge clk);
		sel[3] <= 8'h9f;
		pos <= alo;
		w(2);
		ck("op area in", 1'h1, t[3]);
		@(posedge clk);
		pos <= ahi + 32'sh0000_0001;
		w(2);
		ck("op area out", 1'h0, t[3]);
		$display("test area done");
	endtask

	task automatic t_safe();
		@(posedge clk);
		sel[0] <= 8'hac;
		sel[1] <= 8'had;
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clk);
			so1 <= !s[0];
			so2 <= !s[1];
			w(8);
			ck("both off", s == 3, t[0]);
			ck("any off", s != 0, t[1]);
		end
		$display("test safe off done");
	endtask

	task automatic t_user();
		@(posedge clk);
		sel[0] <= 8'hb4;
		sel[1] <= 8'hb5;
		for (int s = 0; s < 5; s++)
		begin
			@(posedge clk);
			lv <= (s == 4) ? 15'h0001 : 15'(s);
			u0op <= (s == 4);
			u1op <= (s != 4);
			w(3);
			ck("user and", s == 3 || s == 4, t[0]);
			ck("user or", s != 0 && s != 4, t[1]);
		end
		@(posedge clk);
		lv <= '0;
		$display("test user done");
	endtask

	task automatic t_latch();
		@(posedge clk);
		sel[0] <= 8'hc8;
		sel[1] <= 8'hc9;
		sel[2] <= 8'hca;
		for (int b = 0; b < 3; b++)
		begin
			pm(8'h10 << b);
			ck("latch set", 1'h1, t[b]);
		end
		pm(8'h80);
		ck("latch cleared", 1'h0, t[1]);
		ck("step cleared", 1'h0, t[2]);
		pm(8'h90);
		ck("set beats clear", 1'h1, t[0]);
		$display("test latch done");
	endtask

	task automatic t_misc();
		@(posedge clk);
		sel[3] <= 8'hce;
		for (int j = 0; j < 3; j++)
		begin
			@(posedge clk);
			trq <= 16'h03e7 + 16'(j);
			w(2);
			ck("overload", j != 0, t[3]);
		end
		@(posedge clk);
		sel[0] <= 8'h80;
		sel[1] <= 8'h00;
		sel[2] <= 8'h96;
		sel[3] <= 8'hff;
		lv <= '1;
		w(2);
		for (int k = 0; k < 4; k++)
			ck("inactive code", 1'h0, t[k]);
		$display("test codes done");
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		w(2);
		ck("reset terminal", 1'h0, t[0]);
		t_levels();
		t_home();
		t_wrap();
		t_rev();
		t_area();
		t_safe();
		t_user();
		t_latch();
		t_misc();
		close_out();
	end
endmodule

`default_nettype wire
